// ---- psa_regs.sv ----
// APB register bank for segment four and five amplitudes of four channels
`timescale 1ns/1ps

module psa_regs
  import psa_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_CH-1:0] arb_mode,
  input wire logic [NUM_CH-1:0] pulse_start,
  input wire logic [7:0] other_seg_amp [NUM_CH][SEG_COUNT],
  output logic [NUM_CH-1:0] seg_active,
  output logic [2:0] seg_index [NUM_CH],
  output logic [NUM_CH-1:0] seg_sign,
  output logic [MAG_W-1:0] seg_mag [NUM_CH]
);
  logic [7:0] seg4_amp_ff [NUM_CH];
  logic [7:0] seg5_amp_ff [NUM_CH];
  logic ack_ff;
  logic err_ff;
  logic [DATA_W-1:0] rdata_ff;

  // Two-cycle access: first access cycle decodes, second answers from flops
  wire logic access = psel && penable;
  wire logic first_access = access && !ack_ff;
  wire logic wr_fire = access && ack_ff && pwrite && !err_ff && pstrb[0];
  wire logic aligned = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:9] == 3'h0);
  wire logic [IDX_W-1:0] reg_idx = paddr[8:2];

  logic [NUM_CH-1:0] hit4;
  logic [NUM_CH-1:0] hit5;
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_dec
      assign hit4[ch] = aligned && (paddr == psa_byte_addr(SEG4_IDX[ch]));
      assign hit5[ch] = aligned && (paddr == psa_byte_addr(SEG5_IDX[ch]));
    end
  endgenerate

  wire logic hit_status = aligned && (reg_idx == IDX_STATUS);
  wire logic mapped = (|hit4) || (|hit5) || hit_status;

  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    for (int i = 0; i < NUM_CH; i++) begin
      if (hit4[i]) begin
        rd_byte = seg4_amp_ff[i];
      end else if (hit5[i]) begin
        rd_byte = seg5_amp_ff[i];
      end
    end
    if (hit_status) begin
      rd_byte = {4'h0, seg_active};
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ack_ff <= 1'b0;
      err_ff <= 1'b0;
      rdata_ff <= '0;
    end else begin
      ack_ff <= first_access;
      if (first_access) begin
        err_ff <= !mapped;
        rdata_ff <= {24'h000000, rd_byte};
      end
    end
  end

  // Whole byte including the reserved bit is stored and read back
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_regs
      always_ff @(posedge clock) begin
        if (rst) begin
          seg4_amp_ff[ch] <= AMP_RST;
          seg5_amp_ff[ch] <= AMP_RST;
        end else begin
          if (wr_fire && hit4[ch]) begin
            seg4_amp_ff[ch] <= pwdata[7:0];
          end
          if (wr_fire && hit5[ch]) begin
            seg5_amp_ff[ch] <= pwdata[7:0];
          end
        end
      end

      logic [7:0] amps [SEG_COUNT];
      always_comb begin
        for (int s = 0; s < SEG_COUNT; s++) begin
          amps[s] = other_seg_amp[ch][s];
        end
        amps[SEG4_POS] = seg4_amp_ff[ch];
        amps[SEG5_POS] = seg5_amp_ff[ch];
      end

      // Separate sequencer per channel keeps channels independent
      psa_seg_gen u_gen (
        .clock(clock),
        .rst(rst),
        .arb_mode(arb_mode[ch]),
        .pulse_start(pulse_start[ch]),
        .seg_amp(amps),
        .active(seg_active[ch]),
        .seg_index(seg_index[ch]),
        .seg_sign(seg_sign[ch]),
        .seg_mag(seg_mag[ch])
      );
    end
  endgenerate

  assign pready = access && ack_ff;
  assign pslverr = pready && err_ff;
  assign prdata = rdata_ff;

  AST_RESET_ZERO: assert property (@(posedge clock)
    rst |=> (seg4_amp_ff[2] == AMP_RST) && (seg5_amp_ff[1] == AMP_RST))
    else $error("amplitude register not zero after reset");

  AST_WR_SEG4: assert property (@(posedge clock) disable iff (rst)
    (pready && pwrite && pstrb[0] && paddr == psa_byte_addr(IDX_CH2_SEG4))
      |=> seg4_amp_ff[2] == $past(pwdata[7:0]))
    else $error("segment four write to channel two lost");

  AST_WR_SEG5: assert property (@(posedge clock) disable iff (rst)
    (pready && pwrite && pstrb[0] && paddr == psa_byte_addr(IDX_CH3_SEG5))
      |=> seg5_amp_ff[3] == $past(pwdata[7:0]))
    else $error("segment five write to channel three lost");

  AST_CH_INDEP: assert property (@(posedge clock) disable iff (rst)
    (pready && pwrite && paddr == psa_byte_addr(IDX_CH0_SEG4))
      |=> $stable(seg4_amp_ff[1]) && $stable(seg5_amp_ff[0]))
    else $error("write to channel zero disturbed another register");

  AST_READ_BACK: assert property (@(posedge clock) disable iff (rst)
    (first_access && !pwrite && paddr == psa_byte_addr(IDX_CH1_SEG5))
      |=> pready && !pslverr && prdata == {24'h000000, $past(seg5_amp_ff[1])})
    else $error("read of channel one segment five wrong");

  AST_UNMAPPED: assert property (@(posedge clock) disable iff (rst)
    (first_access && !mapped) |=> pready && pslverr ##1 !pready)
    else $error("unmapped access not answered with error");
endmodule

// ---- psa_pkg.sv ----
// Package: register map, field layout and timing constants of the segment amplitude bank
package psa_pkg;
  localparam int NUM_CH = 4;
  localparam int SEG_COUNT = 8;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int IDX_W = 7;
  // Register indices; byte address is four times the index
  localparam logic [6:0] IDX_CH0_SEG4 = 7'h0B;
  localparam logic [6:0] IDX_CH1_SEG4 = 7'h1B;
  localparam logic [6:0] IDX_CH2_SEG4 = 7'h2B;
  localparam logic [6:0] IDX_CH3_SEG4 = 7'h3B;
  localparam logic [6:0] IDX_CH0_SEG5 = 7'h0C;
  localparam logic [6:0] IDX_CH1_SEG5 = 7'h1C;
  localparam logic [6:0] IDX_CH2_SEG5 = 7'h2C;
  localparam logic [6:0] IDX_CH3_SEG5 = 7'h3C;
  localparam logic [6:0] IDX_STATUS = 7'h40;
  localparam logic [6:0] SEG4_IDX [NUM_CH] = '{IDX_CH0_SEG4, IDX_CH1_SEG4, IDX_CH2_SEG4,
                                               IDX_CH3_SEG4};
  localparam logic [6:0] SEG5_IDX [NUM_CH] = '{IDX_CH0_SEG5, IDX_CH1_SEG5, IDX_CH2_SEG5,
                                               IDX_CH3_SEG5};
  // Amplitude field layout
  localparam int SIGN_POS = 6;
  localparam int MAG_W = 6;
  localparam int RSVD_POS = 7;
  localparam logic [7:0] AMP_RST = 8'h00;
  // Segment positions of the two registers held here (zero based)
  localparam int SEG4_POS = 3;
  localparam int SEG5_POS = 4;
  // Timing: one master clock period split in eight segments
  localparam int CLK_PERIOD_NS = 10;
  localparam int MCLK_PERIOD_NS = 640;
  localparam int SEG_CYCLES_RAW = MCLK_PERIOD_NS / (SEG_COUNT * CLK_PERIOD_NS);
  localparam int SEG_CYCLES = (SEG_CYCLES_RAW < 1) ? 1 : SEG_CYCLES_RAW;

  typedef enum logic {PSA_IDLE, PSA_RUN} psa_state_t;

  function automatic logic [ADDR_W-1:0] psa_byte_addr(input logic [IDX_W-1:0] idx);
    psa_byte_addr = {3'h0, idx, 2'h0};
  endfunction
endpackage

// ---- psa_seg_gen.sv ----
// One channel's arbitrary pulse sequencer: eight segments in one master clock period
`timescale 1ns/1ps
module psa_seg_gen
  import psa_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic arb_mode,
  input wire logic pulse_start,
  input wire logic [7:0] seg_amp [SEG_COUNT],
  output logic active,
  output logic [2:0] seg_index,
  output logic seg_sign,
  output logic [MAG_W-1:0] seg_mag
);
  localparam int PULSE_LEN = SEG_COUNT * SEG_CYCLES;
  localparam logic [7:0] SEG_LAST = 8'(SEG_CYCLES - 1);

  psa_state_t state_ff;
  psa_state_t nxt_state;
  logic [7:0] cyc_ff;
  logic [7:0] nxt_cyc;
  logic [2:0] seg_ff;
  logic [2:0] nxt_seg;
  logic sign_ff;
  logic [MAG_W-1:0] mag_ff;
  wire logic [7:0] cur_amp = seg_amp[seg_ff];
  wire logic seg_end = (cyc_ff == SEG_LAST);
  wire logic run = (state_ff == PSA_RUN);

  always_comb begin
    nxt_state = state_ff;
    nxt_cyc = cyc_ff;
    nxt_seg = seg_ff;
    case (state_ff)
      PSA_IDLE: begin
        nxt_cyc = 8'h00;
        nxt_seg = 3'h0;
        if (pulse_start && arb_mode) begin
          nxt_state = PSA_RUN;
        end
      end
      PSA_RUN: begin
        // Eight equal segments fill exactly one master period
        if (!arb_mode) begin
          nxt_state = PSA_IDLE;
        end else if (seg_end) begin
          nxt_cyc = 8'h00;
          nxt_seg = 3'(seg_ff + 3'h1);
          if (seg_ff == 3'(SEG_COUNT - 1)) begin
            nxt_state = PSA_IDLE;
          end
        end else begin
          nxt_cyc = 8'(cyc_ff + 8'h01);
        end
      end
      default: nxt_state = PSA_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= PSA_IDLE;
      cyc_ff <= 8'h00;
      seg_ff <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      cyc_ff <= nxt_cyc;
      seg_ff <= nxt_seg;
    end
  end

  // Sign and magnitude only; the reserved bit never reaches the driver
  always_ff @(posedge clock) begin
    if (rst) begin
      sign_ff <= 1'b0;
      mag_ff <= '0;
    end else begin
      sign_ff <= run && cur_amp[SIGN_POS];
      mag_ff <= run ? cur_amp[MAG_W-1:0] : '0;
    end
  end

  assign active = run;
  assign seg_index = seg_ff;
  assign seg_sign = sign_ff;
  assign seg_mag = mag_ff;

  AST_SIGN_MAG: assert property (@(posedge clock) disable iff (rst)
    run |=> (seg_sign == $past(cur_amp[SIGN_POS])) && (seg_mag == $past(cur_amp[MAG_W-1:0])))
    else $error("segment output does not follow sign and magnitude");

  // Cycles spent running; long pulses are checked on a counter, not a repetition
  localparam logic [7:0] RUN_LAST = 8'(PULSE_LEN - 1);
  logic [7:0] run_cnt_ff;
  always_ff @(posedge clock) begin
    if (rst || !run) begin
      run_cnt_ff <= 8'h00;
    end else begin
      run_cnt_ff <= 8'(run_cnt_ff + 8'h01);
    end
  end

  AST_PULSE_LEN: assert property (@(posedge clock) disable iff (rst)
    (run && arb_mode && run_cnt_ff == RUN_LAST) |=> !run)
    else $error("arbitrary pulse longer than one master period");

  AST_PULSE_FULL: assert property (@(posedge clock) disable iff (rst)
    (run && arb_mode && run_cnt_ff != RUN_LAST) |=> run)
    else $error("arbitrary pulse shorter than one master period");
endmodule

// ---- psa_regs_tb_top.sv ----
// Self-checking bench for the segment amplitude register bank
`timescale 1ns/1ps
module psa_regs_tb_top
  import psa_pkg::*;
;
  logic clock, rst, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [NUM_CH-1:0] arb_mode, pulse_start, seg_active, seg_sign;
  logic [7:0] other_seg_amp [NUM_CH][SEG_COUNT];
  logic [2:0] seg_index [NUM_CH];
  logic [MAG_W-1:0] seg_mag [NUM_CH];
  logic [32:0] exp_q [$];
  logic [31:0] seed;
  logic [7:0] mdl [8];
  int err_count, cmp_count;

  psa_regs uut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .arb_mode(arb_mode), .pulse_start(pulse_start),
    .other_seg_amp(other_seg_amp), .seg_active(seg_active), .seg_index(seg_index),
    .seg_sign(seg_sign), .seg_mag(seg_mag));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Index 0..3 are segment four of channels 0..3, 4..7 segment five
  function automatic logic [11:0] reg_addr(input int i);
    return {3'h0, (i < 4) ? SEG4_IDX[i] : SEG5_IDX[i-4], 2'h0};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, s);
      err_count++;
    end
  endtask

  // Expected answer noted before the request goes out
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    int n;
    n = 0;
    exp_q.push_back(e);
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && n < 40) begin
      @(posedge clock);
      n++;
    end
    if (n == 40) begin
      err_count++;
      results();
    end
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // Answer taken at the rising edge where pready is sampled high
  always @(posedge clock) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      logic [32:0] e;
      e = exp_q.pop_front();
      chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
      if (!pwrite) chk("prdata", e[31:0], prdata);
    end
  end

  task automatic wait_seg(input int c, input logic [2:0] s);
    int n;
    n = 0;
    while (seg_index[c] !== s && n < 200) begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
  endtask

  task automatic results();
    $display("counts: %0d compares, %0d mismatches", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #200000;
    err_count++;
    results();
  end

  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    pstrb = 4'hF; arb_mode = '0; pulse_start = '0; seed = 32'h749294f8;
    err_count = 0; cmp_count = 0;
    for (int c = 0; c < NUM_CH; c++) for (int s = 0; s < SEG_COUNT; s++) begin
      seed = lfsr(seed);
      other_seg_amp[c][s] = seed[7:0];
    end
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) apb(1'b0, reg_addr(i), 32'h0, 33'h0);
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      mdl[i] = seed[7:0] | 8'h80;
      apb(1'b1, reg_addr(i), {seed[31:8], mdl[i]}, 33'h0);
    end
    for (int i = 0; i < 8; i++) apb(1'b0, reg_addr(i), 32'h0, {25'h0, mdl[i]});
    $display("test decode and readback done");
    apb(1'b0, 12'h034, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 12'h02D, 32'h0000_00FF, {1'b1, 32'h0});
    @(posedge clock) pstrb <= 4'h0;
    apb(1'b1, reg_addr(6), 32'h0000_0055, 33'h0);
    @(posedge clock) pstrb <= 4'hF;
    apb(1'b0, reg_addr(0), 32'h0, {25'h0, mdl[0]});
    apb(1'b0, reg_addr(6), 32'h0, {25'h0, mdl[6]});
    $display("test refusals done");
    for (int c = 0; c < NUM_CH; c++) begin
      @(posedge clock);
      arb_mode <= 4'hF;
      pulse_start <= 4'(1 << c);
      @(posedge clock) pulse_start <= '0;
      @(negedge clock);
      chk("seg_active", 32'(1 << c), 32'(seg_active));
      wait_seg(c, 3'd3);
      chk("seg4_sign_bit", 32'(mdl[c][6]), 32'(seg_sign[c]));
      chk("seg4_magnitude", 32'(mdl[c][5:0]), 32'(seg_mag[c]));
      wait_seg(c, 3'd4);
      chk("seg5_sign_bit", 32'(mdl[c+4][6]), 32'(seg_sign[c]));
      chk("seg5_magnitude", 32'(mdl[c+4][5:0]), 32'(seg_mag[c]));
      wait_seg(c, 3'd7);
      repeat (SEG_CYCLES + 2) @(negedge clock);
      chk("pulse end", 32'h0, 32'(seg_active));
      @(posedge clock) arb_mode <= '0;
    end
    $display("test pulse shaping done");
    results();
  end
endmodule
